// *** design/fsr_top.sv ***
// Fault sensor response unit: alarm routing, cause reporting, stack limits,
// high-voltage status and memory byte correction.
// Assumes mode control, memory and core signals share clock_in; alarms are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module fsr_top #(
    parameter int SPW = 16
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic volt_alarm_in,
    input wire logic freq_alarm_in,
    input wire logic temp_alarm_in,
    input wire logic light_alarm_in,
    input wire logic nvm_light_a_in,
    input wire logic nvm_light_b_in,
    input wire logic fault_pc_in,
    input wire logic fault_sp_in,
    input wire logic fault_psh_in,
    input wire logic fault_cipher_in,
    input wire logic fault_arith_in,
    input wire logic hv_low_in,
    input wire logic rom_parity_err_in,
    input wire logic test_mode_in,
    input wire logic test_lock_fuse_in,
    input wire logic nvm_write_in,
    input wire logic [11:0] nvm_code_in,
    input wire logic cfg_wr_in,
    input wire logic [1:0] cfg_lsel_in,
    input wire logic [fsr_pkg::EC_W-1:0] exc_clr_in,
    input wire logic [fsr_pkg::RC_W-1:0] cause_clr_in,
    input wire logic [1:0] cpu_mode_in,
    input wire logic sp_load_in,
    input wire logic [SPW-1:0] sp_load_val_in,
    input wire logic sp_push_in,
    input wire logic sp_pop_in,
    input wire logic lim_wr_in,
    input wire logic [1:0] lim_mode_in,
    input wire logic [SPW-1:0] lim_lo_in,
    input wire logic [SPW-1:0] lim_hi_in,
    output logic chip_reset_out,
    output logic exc_req_out,
    output logic [fsr_pkg::EC_W-1:0] exc_cause_out,
    output logic [fsr_pkg::RC_W-1:0] rst_cause_out,
    output logic sensor_en_out,
    output logic [1:0] lsel_out,
    output logic hv_checked_out,
    output logic hv_fail_out,
    output logic [7:0] nvm_byte_out,
    output logic [SPW-1:0] sp_out
);
    import fsr_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        fsr_state_t st;
        logic [HOLD_W-1:0] hold_cnt;
        logic chip_rst;
        logic [RC_W-1:0] rst_cause;
        logic [EC_W-1:0] exc_cause;
        logic exc_req;
        logic [1:0] lsel;
        logic sens_en;
        logic wr_prev;
        logic hv_checked;
        logic hv_fail;
        logic [7:0] nvm_byte;
        logic [2:0][SPW-1:0] sp;
        logic [2:0][SPW-1:0] lim_lo;
        logic [2:0][SPW-1:0] lim_hi;
        logic [SPW-1:0] sp_view;
    } fsr_reg_t;

    fsr_reg_t r_ff;
    fsr_reg_t nxt_r;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] fsr_ecc_fix(input logic [11:0] cw);
        logic [3:0] syn;
        logic [11:0] c;
        syn = 4'h0;
        c = cw;
        for (int i = 1; i <= 12; i++) begin
            if (cw[i-1]) begin
                syn = syn ^ 4'(i);
            end
        end
        if (syn != 4'h0 && syn <= 4'hc) begin
            c[syn - 4'h1] = ~cw[syn - 4'h1];
        end
        return {c[11], c[10], c[9], c[8], c[6], c[5], c[4], c[2]};
    endfunction

    function automatic logic fsr_sp_hit(input logic [SPW-1:0] sp,
                                        input logic [SPW-1:0] lo,
                                        input logic [SPW-1:0] hi);
        return (sp == lo) || (sp == hi);
    endfunction

    function automatic logic fsr_mode_ok(input logic [1:0] m);
        return m != 2'b11;
    endfunction

    // ****************************************
    // Alarm synchronisation
    // ****************************************
    logic [SY_W-1:0] alarm_raw;
    logic [SY_W-1:0] alarm_sy;

    assign alarm_raw = {hv_low_in, fault_arith_in, fault_cipher_in, fault_psh_in,
                        fault_sp_in, fault_pc_in, nvm_light_b_in, nvm_light_a_in,
                        light_alarm_in, temp_alarm_in, freq_alarm_in, volt_alarm_in};

    fsr_sync #(
        .W(SY_W)
    ) u_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in(alarm_raw),
        .sync_out(alarm_sy)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    logic sens_en;
    logic [RC_W-1:0] rst_src;
    logic [EC_W-1:0] exc_src;
    logic lsel_hit;
    logic [1:0] mode;
    logic [SPW-1:0] sp_new;
    logic sp_op;

    always_comb begin
        nxt_r = r_ff;
        // Sensors on unless test mode is live and the test lock fuse is intact
        sens_en = ~(test_mode_in & ~test_lock_fuse_in);
        // Hard-wired routing: these sources can only ever reset
        rst_src = '0;
        rst_src[RC_VOLT] = sens_en & alarm_sy[SY_RST_LO + RC_VOLT];
        rst_src[RC_FREQ] = sens_en & alarm_sy[SY_RST_LO + RC_FREQ];
        rst_src[RC_TEMP] = sens_en & alarm_sy[SY_RST_LO + RC_TEMP];
        rst_src[RC_LIGHT] = sens_en & alarm_sy[SY_RST_LO + RC_LIGHT];
        rst_src[RC_PARITY] = rom_parity_err_in;
        case (fsr_lsel_t'(r_ff.lsel))
            FSR_LSEL_A: lsel_hit = alarm_sy[SY_LA];
            FSR_LSEL_B: lsel_hit = alarm_sy[SY_LB];
            default: lsel_hit = 1'b0;
        endcase
        // Hard-wired routing: these sources can only ever raise an exception
        exc_src = '0;
        exc_src[EC_NVM_LIGHT] = sens_en & lsel_hit;
        exc_src[EC_PC] = sens_en & alarm_sy[SY_FLT_LO];
        exc_src[EC_SP] = sens_en & alarm_sy[SY_FLT_LO + 1];
        exc_src[EC_PSH] = sens_en & alarm_sy[SY_FLT_LO + 2];
        exc_src[EC_CIPHER] = sens_en & alarm_sy[SY_FLT_LO + 3];
        exc_src[EC_ARITH] = sens_en & alarm_sy[SY_FLT_LO + 4];

        // Stack pointer of the active mode
        mode = cpu_mode_in;
        sp_op = fsr_mode_ok(mode) & (sp_load_in | sp_push_in | sp_pop_in);
        sp_new = '0;
        if (fsr_mode_ok(mode)) begin
            sp_new = r_ff.sp[mode];
            if (sp_load_in) begin
                sp_new = sp_load_val_in;
            end else if (sp_push_in && !sp_pop_in) begin
                sp_new = r_ff.sp[mode] + SPW'(1);
            end else if (sp_pop_in && !sp_push_in) begin
                sp_new = r_ff.sp[mode] - SPW'(1);
            end
            if (sp_op) begin
                nxt_r.sp[mode] = sp_new;
                exc_src[EC_STACK] = fsr_sp_hit(sp_new, r_ff.lim_lo[mode],
                                               r_ff.lim_hi[mode]);
            end
            nxt_r.sp_view = sp_new;
        end
        if (lim_wr_in && fsr_mode_ok(lim_mode_in)) begin
            nxt_r.lim_lo[lim_mode_in] = lim_lo_in;
            nxt_r.lim_hi[lim_mode_in] = lim_hi_in;
        end

        if (cfg_wr_in) begin
            nxt_r.lsel = cfg_lsel_in;
        end
        nxt_r.sens_en = sens_en;

        // Exception causes: set wins over software clear
        nxt_r.exc_cause = (r_ff.exc_cause & ~exc_clr_in) | exc_src;
        nxt_r.exc_req = |nxt_r.exc_cause;

        // Reset causes: survive forced resets, set wins over clear
        nxt_r.rst_cause = (r_ff.rst_cause & ~cause_clr_in) | rst_src;

        // High-voltage check during each write sequence, status only
        nxt_r.wr_prev = nvm_write_in;
        if (nvm_write_in && !r_ff.wr_prev) begin
            nxt_r.hv_checked = 1'b1;
            nxt_r.hv_fail = alarm_sy[SY_HV];
        end else if (nvm_write_in && alarm_sy[SY_HV]) begin
            nxt_r.hv_fail = 1'b1;
        end

        nxt_r.nvm_byte = fsr_ecc_fix(nvm_code_in);

        // Forced chip reset sequence
        case (r_ff.st)
            FSR_ST_RUN: begin
                if (|rst_src) begin
                    nxt_r.st = FSR_ST_HOLD;
                    nxt_r.chip_rst = 1'b1;
                    nxt_r.hold_cnt = HOLD_W'(RST_HOLD_CYC - 1);
                end
            end
            FSR_ST_HOLD: begin
                if (|rst_src) begin
                    nxt_r.hold_cnt = HOLD_W'(RST_HOLD_CYC - 1);
                end else if (r_ff.hold_cnt == '0) begin
                    nxt_r.st = FSR_ST_RUN;
                    nxt_r.chip_rst = 1'b0;
                end else begin
                    nxt_r.hold_cnt = r_ff.hold_cnt - HOLD_W'(1);
                end
            end
            default: begin
                nxt_r.st = FSR_ST_RUN;
                nxt_r.chip_rst = 1'b0;
            end
        endcase

        // Under a forced reset everything but the reset cause and the sensor enable returns to reset value
        if (r_ff.st == FSR_ST_HOLD) begin
            nxt_r.exc_cause = '0;
            nxt_r.exc_req = 1'b0;
            nxt_r.lsel = LSEL_RST;
            nxt_r.hv_checked = 1'b0;
            nxt_r.hv_fail = 1'b0;
            nxt_r.wr_prev = 1'b0;
            nxt_r.sp = '0;
            nxt_r.lim_lo = '0;
            nxt_r.lim_hi = '0;
            nxt_r.sp_view = '0;
            nxt_r.nvm_byte = '0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign chip_reset_out = r_ff.chip_rst;
    assign exc_req_out = r_ff.exc_req;
    assign exc_cause_out = r_ff.exc_cause;
    assign rst_cause_out = r_ff.rst_cause;
    assign sensor_en_out = r_ff.sens_en;
    assign lsel_out = r_ff.lsel;
    assign hv_checked_out = r_ff.hv_checked;
    assign hv_fail_out = r_ff.hv_fail;
    assign nvm_byte_out = r_ff.nvm_byte;
    assign sp_out = r_ff.sp_view;
endmodule
`default_nettype wire

// *** design/fsr_pkg.sv ***
// Constants and types of the fault sensor response unit.
// Assumes one 125 MHz clock and a synchronous active-high reset from power-up.
package fsr_pkg;

    localparam int CLK_NS = 8;
    localparam int RST_HOLD_NS = 800;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_W = 8;

    // Reset cause bit positions
    localparam int RC_VOLT = 0;
    localparam int RC_FREQ = 1;
    localparam int RC_TEMP = 2;
    localparam int RC_LIGHT = 3;
    localparam int RC_PARITY = 4;
    localparam int RC_W = 5;

    // Exception cause bit positions
    localparam int EC_NVM_LIGHT = 0;
    localparam int EC_PC = 1;
    localparam int EC_SP = 2;
    localparam int EC_PSH = 3;
    localparam int EC_CIPHER = 4;
    localparam int EC_ARITH = 5;
    localparam int EC_STACK = 6;
    localparam int EC_W = 7;

    // Synchronised alarm vector layout
    localparam int SY_RST_LO = 0;
    localparam int SY_LA = 4;
    localparam int SY_LB = 5;
    localparam int SY_FLT_LO = 6;
    localparam int SY_HV = 11;
    localparam int SY_W = 12;

    typedef enum logic [1:0] {
        FSR_MODE_USER = 2'b00,
        FSR_MODE_SYS = 2'b01,
        FSR_MODE_SUPER = 2'b10
    } fsr_mode_t;

    typedef enum logic [1:0] {
        FSR_LSEL_OFF = 2'b00,
        FSR_LSEL_A = 2'b01,
        FSR_LSEL_B = 2'b10,
        FSR_LSEL_OFF2 = 2'b11
    } fsr_lsel_t;

    typedef enum logic [0:0] {
        FSR_ST_RUN = 1'b0,
        FSR_ST_HOLD = 1'b1
    } fsr_state_t;

    localparam logic [1:0] LSEL_RST = 2'b00;

endpackage

// *** design/fsr_sync.sv ***
// Two-flop synchroniser for a vector of independent level signals.
// Assumes each bit is a slow level; no multi-bit coherence is promised.
`timescale 1ns/100ps
`default_nettype none
module fsr_sync #(
    parameter int W = 1
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule
`default_nettype wire

// *** tb/fsr_core_model.sv ***
// Core model: software handler that clears exception and reset causes.
// Assumes design outputs settle before the falling edge of clock_in.
`timescale 1ns/100ps
`default_nettype none
module fsr_core_model (
    input wire logic clock_in,
    input wire logic chip_reset_in,
    input wire logic exc_req_in,
    input wire logic [fsr_pkg::EC_W-1:0] exc_cause_in,
    input wire logic [fsr_pkg::RC_W-1:0] rst_cause_in,
    output logic [fsr_pkg::EC_W-1:0] exc_clr_out,
    output logic [fsr_pkg::RC_W-1:0] cause_clr_out
);
    import fsr_pkg::*;
    initial begin
        exc_clr_out = '0;
        cause_clr_out = '0;
        forever begin
            @(negedge clock_in);
            if (exc_req_in === 1'b1) begin
                repeat (6 + $urandom % 6) @(negedge clock_in);
                exc_clr_out = exc_cause_in;
                @(negedge clock_in);
                exc_clr_out = '0;
            end else if (rst_cause_in !== '0 && chip_reset_in === 1'b0) begin
                repeat (6 + $urandom % 6) @(negedge clock_in);
                cause_clr_out = rst_cause_in;
                @(negedge clock_in);
                cause_clr_out = '0;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/fsr_top_asserts.sv ***
// Checker of the fault sensor response unit, bound to fsr_top.
// Assumes the single clock domain of clock_in with reset rst_in.
`timescale 1ns/100ps
`default_nettype none
module fsr_top_asserts #(
    parameter int SPW = 16
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic volt_alarm_in,
    input wire logic fault_pc_in,
    input wire logic rom_parity_err_in,
    input wire logic test_mode_in,
    input wire logic test_lock_fuse_in,
    input wire logic nvm_write_in,
    input wire logic cfg_wr_in,
    input wire logic [1:0] cfg_lsel_in,
    input wire logic [fsr_pkg::RC_W-1:0] cause_clr_in,
    input wire logic [1:0] cpu_mode_in,
    input wire logic sp_load_in,
    input wire logic sp_push_in,
    input wire logic sp_pop_in,
    input wire logic chip_reset_out,
    input wire logic exc_req_out,
    input wire logic [fsr_pkg::EC_W-1:0] exc_cause_out,
    input wire logic [fsr_pkg::RC_W-1:0] rst_cause_out,
    input wire logic sensor_en_out,
    input wire logic [1:0] lsel_out,
    input wire logic hv_checked_out,
    input wire logic [SPW-1:0] sp_out
);
    import fsr_pkg::*;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic [7:0] hold_ff;
    always_ff @(posedge clock_in) begin
        hold_ff <= (rst_in || !chip_reset_out) ? 8'h00 : hold_ff + 8'h01;
    end
    sequence s_volt_live;
        (volt_alarm_in && sensor_en_out)[*3];
    endsequence
    sequence s_fault_live;
        (fault_pc_in && sensor_en_out && !chip_reset_out)[*3];
    endsequence
    sequence s_push_pair;
        (sp_push_in && !sp_pop_in && !sp_load_in && cpu_mode_in != 2'b11 && !chip_reset_out)[*2]
            ##0 $stable(cpu_mode_in);
    endsequence
    volt_reset_a: assert property (s_volt_live |=> chip_reset_out && rst_cause_out[RC_VOLT])
        else $error("volt alarm did not force reset");
    parity_reset_a: assert property (rom_parity_err_in |-> ##[1:2] chip_reset_out && rst_cause_out[RC_PARITY])
        else $error("parity error did not force reset");
    fault_exc_a: assert property (s_fault_live |=> exc_cause_out[EC_PC] || chip_reset_out)
        else $error("pc fault raised no exception");
    req_cause_a: assert property (exc_req_out == (|exc_cause_out))
        else $error("exception request differs from causes");
    hold_len_a: assert property ($fell(chip_reset_out) |-> hold_ff >= RST_HOLD_CYC - 1)
        else $error("forced reset too short");
    cause_sticky_a: assert property ((($past(rst_cause_out) & ~rst_cause_out & ~$past(cause_clr_in)) == '0))
        else $error("reset cause lost without clear");
    sensor_on_a: assert property (!$past(rst_in) |-> sensor_en_out == !$past(test_mode_in && !test_lock_fuse_in))
        else $error("sensor enable wrong");
    push_step_a: assert property (s_push_pair |=> sp_out == $past(sp_out) + 1'b1 || chip_reset_out)
        else $error("push did not step pointer");
    lsel_write_a: assert property (cfg_wr_in && !chip_reset_out |=> lsel_out == $past(cfg_lsel_in) || chip_reset_out)
        else $error("light select not written");
    hv_check_a: assert property ($rose(nvm_write_in) && !chip_reset_out |=> hv_checked_out || chip_reset_out)
        else $error("write start not checked");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of fsr_top with a software core model.
// Assumes a 125 MHz clock and inputs driven at the falling edge.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
    import fsr_pkg::*;
    logic clock_in, rst_in, hv_low_in, test_mode_in, test_lock_fuse_in, nvm_write_in, cfg_wr_in;
    logic sp_load_in, sp_push_in, sp_pop_in, lim_wr_in, chip_reset_out, exc_req_out, sensor_en_out;
    logic hv_checked_out, hv_fail_out;
    logic [4:0] rs;
    logic [6:0] xs;
    logic [11:0] nvm_code_in;
    logic [1:0] cfg_lsel_in, cpu_mode_in, lim_mode_in, lsel_out;
    logic [EC_W-1:0] exc_clr_in, exc_cause_out;
    logic [RC_W-1:0] cause_clr_in, rst_cause_out;
    logic [15:0] sp_load_val_in, lim_lo_in, lim_hi_in, sp_out;
    logic [7:0] nvm_byte_out, d;
    logic [15:0] base [3];
    int fail_count = 0;
    int samples_checked = 0;
    fsr_top u_fsr_top (.clock_in, .rst_in, .volt_alarm_in(rs[0]), .freq_alarm_in(rs[1]),
        .temp_alarm_in(rs[2]), .light_alarm_in(rs[3]), .rom_parity_err_in(rs[4]),
        .fault_pc_in(xs[0]), .fault_sp_in(xs[1]), .fault_psh_in(xs[2]), .fault_cipher_in(xs[3]),
        .fault_arith_in(xs[4]), .nvm_light_a_in(xs[5]), .nvm_light_b_in(xs[6]), .hv_low_in,
        .test_mode_in, .test_lock_fuse_in, .nvm_write_in, .nvm_code_in, .cfg_wr_in, .cfg_lsel_in,
        .exc_clr_in, .cause_clr_in, .cpu_mode_in, .sp_load_in, .sp_load_val_in, .sp_push_in,
        .sp_pop_in, .lim_wr_in, .lim_mode_in, .lim_lo_in, .lim_hi_in, .chip_reset_out,
        .exc_req_out, .exc_cause_out, .rst_cause_out, .sensor_en_out, .lsel_out,
        .hv_checked_out, .hv_fail_out, .nvm_byte_out, .sp_out);
    fsr_core_model u_fsr_core_model (.clock_in, .chip_reset_in(chip_reset_out),
        .exc_req_in(exc_req_out), .exc_cause_in(exc_cause_out), .rst_cause_in(rst_cause_out),
        .exc_clr_out(exc_clr_in), .cause_clr_out(cause_clr_in));
    function automatic logic [11:0] enc(input logic [7:0] v);
        logic [11:0] c;
        c = '0;
        {c[11], c[10], c[9], c[8], c[6], c[5], c[4], c[2]} = v;
        for (int p = 0; p < 4; p++)
            for (int i = 1; i <= 12; i++)
                if (i[p] && i != (1 << p)) c[(1 << p) - 1] ^= c[i - 1];
        return c;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic pulse_x(input int i, input logic [EC_W-1:0] e);
        xs[i] = 1'b1;
        tick(3);
        xs[i] = 1'b0;
        tick(0);
        tick(2);
        `CHK("exc_cause", e, exc_cause_out)
        `CHK("exc_req", |e, exc_req_out)
        for (int k = 0; k < 40 && exc_req_out !== 1'b0; k++) tick(1);
        `CHK("exc_clear", '0, exc_cause_out)
    endtask
    task automatic pulse_r(input int i);
        rs[i] = 1'b1;
        tick(3);
        rs[i] = 1'b0;
        `CHK("chip_reset", 1'b1, chip_reset_out)
        `CHK("rst_cause", 5'(1 << i), rst_cause_out)
        tick(1);
        `CHK("sp_cleared", 16'h0000, sp_out)
        for (int k = 0; k < 200 && chip_reset_out !== 1'b0; k++) tick(1);
        `CHK("cause_kept", 5'(1 << i), rst_cause_out)
        for (int k = 0; k < 40 && rst_cause_out !== '0; k++) tick(1);
        `CHK("cause_clr", '0, rst_cause_out)
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    initial begin
        repeat (20000) @(posedge clock_in);
        fail_count++;
        conclude;
    end
    initial begin
        {rs, xs, hv_low_in, test_mode_in, nvm_write_in, nvm_code_in, cfg_wr_in, cfg_lsel_in} = '0;
        {cpu_mode_in, sp_load_in, sp_load_val_in, sp_push_in, sp_pop_in} = '0;
        {lim_wr_in, lim_mode_in, lim_lo_in, lim_hi_in} = '0;
        rst_in = 1'b1;
        test_lock_fuse_in = 1'b1;
        void'($urandom(32'h1caf));
        tick(11);
        rst_in = 1'b0;
        tick(2);
        `CHK("rst_vals", '0, {chip_reset_out, exc_cause_out, rst_cause_out, lsel_out, sp_out})
        `CHK("sensor_en", 1'b1, sensor_en_out)
        for (int m = 0; m < 3; m++) begin
            cpu_mode_in = 2'(m);
            lim_mode_in = 2'(m);
            lim_wr_in = 1'b1;
            base[m] = 16'($urandom % 1000) + 16'h0008;
            lim_lo_in = base[m] - 16'h0004;
            lim_hi_in = base[m] + 16'h0002;
            tick(1);
            lim_wr_in = 1'b0;
            sp_load_in = 1'b1;
            sp_load_val_in = base[m];
            tick(1);
            sp_load_in = 1'b0;
            sp_push_in = 1'b1;
            tick(1);
            `CHK("sp1", base[m] + 16'h0001, sp_out)
            `CHK("stk0", 1'b0, exc_cause_out[EC_STACK])
            tick(1);
            sp_push_in = 1'b0;
            `CHK("sp2", base[m] + 16'h0002, sp_out)
            `CHK("stk1", 1'b1, exc_cause_out[EC_STACK])
            for (int k = 0; k < 40 && exc_req_out !== 1'b0; k++) tick(1);
        end
        cpu_mode_in = 2'b00;
        sp_push_in = 1'b1;
        tick(1);
        sp_push_in = 1'b0;
        `CHK("sp_own", base[0] + 16'h0003, sp_out)
        for (int i = 0; i < 5; i++) pulse_x(i, 7'(2 << i));
        for (int s = 0; s < 4; s++) begin
            cfg_wr_in = 1'b1;
            cfg_lsel_in = 2'(s);
            tick(1);
            cfg_wr_in = 1'b0;
            `CHK("lsel", 2'(s), lsel_out)
            pulse_x(5, 7'(s == 1));
            pulse_x(6, 7'(s == 2));
        end
        for (int i = 0; i < 5; i++) pulse_r(i);
        test_mode_in = 1'b1;
        test_lock_fuse_in = 1'b0;
        tick(2);
        `CHK("sens_test", 1'b0, sensor_en_out)
        rs[0] = 1'b1;
        tick(1);
        rs[0] = 1'b0;
        tick(4);
        `CHK("no_reset", 1'b0, chip_reset_out)
        test_lock_fuse_in = 1'b1;
        tick(2);
        `CHK("sens_fuse", 1'b1, sensor_en_out)
        test_mode_in = 1'b0;
        for (int h = 1; h >= 0; h--) begin
            hv_low_in = 1'(h);
            tick(3);
            nvm_write_in = 1'b1;
            tick(1);
            `CHK("hv_chk", 1'b1, hv_checked_out)
            tick(2);
            nvm_write_in = 1'b0;
            `CHK("hv_fail", 1'(h), hv_fail_out)
            `CHK("hv_quiet", 2'b00, {exc_req_out, chip_reset_out})
            tick(1);
        end
        repeat (60) begin
            d = 8'($urandom);
            nvm_code_in = enc(d) ^ (12'h001 << ($urandom % 13));
            tick(1);
            `CHK("ecc", d, nvm_byte_out)
        end
        conclude;
    end
endmodule
bind fsr_top fsr_top_asserts #(.SPW(SPW)) u_fsr_top_asserts (.clock_in, .rst_in,
    .volt_alarm_in, .fault_pc_in, .rom_parity_err_in, .test_mode_in, .test_lock_fuse_in,
    .nvm_write_in, .cfg_wr_in, .cfg_lsel_in, .cause_clr_in, .cpu_mode_in, .sp_load_in,
    .sp_push_in, .sp_pop_in, .chip_reset_out, .exc_req_out, .exc_cause_out, .rst_cause_out,
    .sensor_en_out, .lsel_out, .hv_checked_out, .sp_out);
`default_nettype wire
